// File: hw/mdec_core.sv
// Instruction decoder and executor of the 14-bit instruction core.
`timescale 1ns/1ps

// How it works
// - Decrement file, skip next when zero.
// - Increment file, skip next when zero.
// - OR accumulator with file, zero flag only.
// - XOR accumulator with file, zero flag only.
// - Rotate left through carry, carry only.
// - Rotate right through carry, carry only.
// - Clear selected bit, flags untouched.
// - Skip next when tested bit clear.
// - Skip next when tested bit set.
// - OR literal into accumulator, zero only.
// - Literal minus accumulator, sets three flags.
// - Return loading literal, pops, two cycles.
// - Standby word enters low power, clears powerdown flag, sets watchdog expired flag.
// - Port read-modify-write uses pin levels.
// - Timer write other than the accumulator move clears assigned prescaler.
// - Branch or true test: second cycle no-op.
module mdec_core #(
    parameter logic [6:0] TIMER_ADDR = 7'h01,
    parameter logic [6:0] PORT_A_ADDR = 7'h05,
    parameter logic [6:0] PORT_B_ADDR = 7'h06
) (
    // Clock and reset.
    input wire logic clk,
    input wire logic rst_b,
    // Fetched instruction and addressed file contents.
    input wire logic instr_valid,
    input wire logic [13:0] instr,
    input wire logic [7:0] file_rdata,
    // Port pin levels.
    input wire logic [7:0] pin_a,
    input wire logic [7:0] pin_b,
    // File register write.
    output mdec_pkg::mdec_fwr_t file_wr,
    // Program counter control.
    output logic flush,
    output logic jump,
    output logic [10:0] jump_addr,
    output logic push,
    output logic pop,
    // Core side effects.
    output logic gie_set,
    output logic sleep_req,
    output logic watchdog_clear,
    output logic presc_clear,
    output mdec_pkg::mdec_flags_t flags,
    output logic [7:0] acc,
    // Register port.
    input wire logic [1:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata
);
    import mdec_pkg::*;

    mdec_state_t state_r;
    mdec_state_t state_nxt;
    logic [7:0] pin_a_meta_r;
    logic [7:0] pin_a_r;
    logic [7:0] pin_b_meta_r;
    logic [7:0] pin_b_r;
    logic presc_assign_r;
    logic [7:0] res_r;
    logic ex_go;
    logic [7:0] src;
    logic [7:0] res;
    logic [7:0] mask;
    logic [2:0] bsel;
    logic byte_wr;
    logic wr_file;
    logic wr_acc;
    logic upd_z;
    logic upd_c;
    logic upd_hc;
    logic c_n;
    logic hc_n;
    logic skip;
    logic do_jump;
    logic do_push;
    logic do_pop;
    logic do_gie;
    logic do_sleep;
    logic do_kick;
    logic is_movwf;
    mdec_sum_t sum;

    function automatic mdec_sum_t add8(input logic [7:0] a,
                                       input logic [7:0] b,
                                       input logic cin);
        logic [4:0] lo;
        logic [8:0] full;
        lo = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
        full = {1'b0, a} + {1'b0, b} + {8'h00, cin};
        add8 = '{hc: lo[4], c: full[8], v: full[7:0]};
    endfunction

    assign ex_go = instr_valid && (state_r == MDEC_S_EXEC);
    assign bsel = instr[9:7];

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            pin_a_meta_r <= 8'h00;
            pin_a_r <= 8'h00;
            pin_b_meta_r <= 8'h00;
            pin_b_r <= 8'h00;
        end else begin
            pin_a_meta_r <= pin_a;
            pin_a_r <= pin_a_meta_r;
            pin_b_meta_r <= pin_b;
            pin_b_r <= pin_b_meta_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Decode and compute.
    always_comb begin
        src = file_rdata;
        if (instr[6:0] == PORT_A_ADDR) begin
            src = pin_a_r;
        end else if (instr[6:0] == PORT_B_ADDR) begin
            src = pin_b_r;
        end
        mask = 8'h01 << bsel;
        res = 8'h00;
        sum = '{hc: 1'b0, c: 1'b0, v: 8'h00};
        byte_wr = 1'b0;
        wr_file = 1'b0;
        wr_acc = 1'b0;
        upd_z = 1'b0;
        upd_c = 1'b0;
        upd_hc = 1'b0;
        c_n = flags.carry;
        hc_n = flags.half_carry_flag;
        skip = 1'b0;
        do_jump = 1'b0;
        do_push = 1'b0;
        do_pop = 1'b0;
        do_gie = 1'b0;
        do_sleep = 1'b0;
        do_kick = 1'b0;
        is_movwf = 1'b0;
        casez (instr[13:8])
            6'b00_0000: begin
                if (instr[7]) begin
                    res = acc;
                    wr_file = 1'b1;
                    is_movwf = 1'b1;
                end else if (instr[7:0] == MDEC_W_RETURN) begin
                    do_pop = 1'b1;
                end else if (instr[7:0] == MDEC_W_INTRET) begin
                    do_pop = 1'b1;
                    do_gie = 1'b1;
                end else if (instr[7:0] == MDEC_W_SLEEP) begin
                    do_sleep = 1'b1;
                end else if (instr[7:0] == MDEC_W_WDKICK) begin
                    do_kick = 1'b1;
                end
            end
            6'b00_0001: begin
                upd_z = 1'b1;
                if (instr[7]) begin
                    wr_file = 1'b1;
                end else if (instr[7:0] == MDEC_W_CLRACC) begin
                    wr_acc = 1'b1;
                end else begin
                    upd_z = 1'b0;
                end
            end
            6'b00_0010, 6'b00_0111: begin
                sum = (instr[8]) ? add8(src, acc, 1'b0) :
                                   add8(src, ~acc, 1'b1);
                res = sum.v;
                c_n = sum.c;
                hc_n = sum.hc;
                byte_wr = 1'b1;
                upd_z = 1'b1;
                upd_c = 1'b1;
                upd_hc = 1'b1;
            end
            6'b00_0011, 6'b00_1010, 6'b00_1011, 6'b00_1111: begin
                // Op fields 1010 and 1111 count up, 0011 and 1011 count down.
                res = (instr[11:8] == 4'b1010 || instr[11:8] == 4'b1111) ?
                      src + 8'h01 : src - 8'h01;
                if (instr[11:8] == 4'b1011 || instr[11:8] == 4'b1111) begin
                    skip = (res == 8'h00);
                end else begin
                    upd_z = 1'b1;
                end
                byte_wr = 1'b1;
            end
            6'b00_0100, 6'b00_0101, 6'b00_0110: begin
                case (instr[9:8])
                    2'b00: res = src | acc;
                    2'b01: res = src & acc;
                    default: res = src ^ acc;
                endcase
                byte_wr = 1'b1;
                upd_z = 1'b1;
            end
            6'b00_1000, 6'b00_1001: begin
                res = (instr[8]) ? ~src : src;
                byte_wr = 1'b1;
                upd_z = 1'b1;
            end
            6'b00_1100: begin
                res = {flags.carry, src[7:1]};
                c_n = src[0];
                byte_wr = 1'b1;
                upd_c = 1'b1;
            end
            6'b00_1101: begin
                res = {src[6:0], flags.carry};
                c_n = src[7];
                byte_wr = 1'b1;
                upd_c = 1'b1;
            end
            6'b00_1110: begin
                res = {src[3:0], src[7:4]};
                byte_wr = 1'b1;
            end
            6'b01_00??: begin
                res = src & ~mask;
                wr_file = 1'b1;
            end
            6'b01_01??: begin
                res = src | mask;
                wr_file = 1'b1;
            end
            6'b01_10??: skip = ((src & mask) == 8'h00);
            6'b01_11??: skip = ((src & mask) != 8'h00);
            6'b10_????: begin
                do_jump = 1'b1;
                do_push = ~instr[11];
            end
            6'b11_00??: begin
                res = instr[7:0];
                wr_acc = 1'b1;
            end
            6'b11_01??: begin
                res = instr[7:0];
                wr_acc = 1'b1;
                do_pop = 1'b1;
            end
            6'b11_1000, 6'b11_1001, 6'b11_1010: begin
                case (instr[9:8])
                    2'b00: res = instr[7:0] | acc;
                    2'b01: res = instr[7:0] & acc;
                    default: res = instr[7:0] ^ acc;
                endcase
                wr_acc = 1'b1;
                upd_z = 1'b1;
            end
            6'b11_110?, 6'b11_111?: begin
                sum = (instr[9]) ? add8(instr[7:0], acc, 1'b0) :
                    add8(instr[7:0], ~acc, 1'b1);
                res = sum.v;
                c_n = sum.c;
                hc_n = sum.hc;
                wr_acc = 1'b1;
                upd_z = 1'b1;
                upd_c = 1'b1;
                upd_hc = 1'b1;
            end
            default: res = 8'h00;
        endcase
        if (byte_wr) begin
            wr_file = instr[7];
            wr_acc = ~instr[7];
        end
    end

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            MDEC_S_EXEC: begin
                if (ex_go && (skip || do_jump || do_pop)) begin
                    state_nxt = MDEC_S_NOP;
                end
            end
            MDEC_S_NOP: state_nxt = MDEC_S_EXEC;
            default: state_nxt = MDEC_S_EXEC;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Sequencing and program counter control.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state_r <= MDEC_S_EXEC;
            flush <= 1'b0;
            jump <= 1'b0;
            jump_addr <= 11'h000;
            push <= 1'b0;
            pop <= 1'b0;
        end else begin
            state_r <= state_nxt;
            flush <= ex_go && (skip || do_jump || do_pop);
            jump <= ex_go && do_jump;
            jump_addr <= instr[10:0];
            push <= ex_go && do_push;
            pop <= ex_go && do_pop;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Results, file writes and side effects.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            file_wr <= '{we: 1'b0, addr: 7'h00, data: 8'h00};
            res_r <= 8'h00;
            gie_set <= 1'b0;
            sleep_req <= 1'b0;
            watchdog_clear <= 1'b0;
            presc_clear <= 1'b0;
        end else begin
            file_wr <= '{we: ex_go && wr_file, addr: instr[6:0], data: res};
            res_r <= res;
            gie_set <= ex_go && do_gie;
            sleep_req <= ex_go && do_sleep;
            watchdog_clear <= ex_go && (do_sleep || do_kick);
            presc_clear <= ex_go && wr_file && !is_movwf &&
                           (instr[6:0] == TIMER_ADDR) &&
                           presc_assign_r;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            acc <= MDEC_ACC_RST;
        end else if (ex_go && wr_acc) begin
            acc <= res;
        end else if (reg_wr && reg_addr == MDEC_OFS_ACC) begin
            acc <= reg_wdata;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            flags <= '{powerdown_flag: MDEC_PWD_RST,
                       watchdog_expired_flag: MDEC_WDX_RST,
                       zero: 1'b0, half_carry_flag: 1'b0, carry: 1'b0};
        end else if (ex_go) begin
            if (upd_z) begin
                flags.zero <= (res == 8'h00);
            end
            if (upd_c) begin
                flags.carry <= c_n;
            end
            if (upd_hc) begin
                flags.half_carry_flag <= hc_n;
            end
            if (do_sleep) begin
                flags.powerdown_flag <= 1'b0;
                flags.watchdog_expired_flag <= 1'b1;
            end else if (do_kick) begin
                flags.powerdown_flag <= 1'b1;
                flags.watchdog_expired_flag <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Register port.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            presc_assign_r <= MDEC_PRESC_RST;
            reg_rdata <= 8'h00;
        end else begin
            if (reg_wr && reg_addr == MDEC_OFS_CTRL) begin
                presc_assign_r <= reg_wdata[MDEC_CTRL_PRESC_BIT];
            end
            reg_rdata <= 8'h00;
            if (reg_rd) begin
                case (reg_addr)
                    MDEC_OFS_CTRL: reg_rdata <= {7'h00, presc_assign_r};
                    MDEC_OFS_ACC: reg_rdata <= acc;
                    MDEC_OFS_STAT: reg_rdata <= {3'h0, flags};
                    default: reg_rdata <= 8'h00;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks.
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);

    sequence s_long_op;
        ex_go && (skip || do_jump || do_pop);
    endsequence
    sequence s_nop_cycle;
        flush && (state_r == MDEC_S_NOP) ##1 !file_wr.we && $stable(acc);
    endsequence

    property p_dec_skip;
        ex_go && instr[13:8] == 6'b00_1011 && src == 8'h01 |=> flush;
    endproperty
    a_dec_skip: assert property (p_dec_skip)
        else $error("decrement to zero did not skip");

    property p_inc_skip;
        ex_go && instr[13:8] == 6'b00_1111 && src != 8'hff |=> !flush;
    endproperty
    a_inc_skip: assert property (p_inc_skip)
        else $error("increment to nonzero skipped");

    property p_or_flags;
        ex_go && instr[13:8] == 6'b00_0100 |=>
            $stable(flags.carry) && flags.zero == (res_r == 8'h00);
    endproperty
    a_or_flags: assert property (p_or_flags)
        else $error("or with file flags wrong");

    property p_xor_val;
        ex_go && instr[13:8] == 6'b00_0110 |=>
            res_r == ($past(src) ^ $past(acc)) && $stable(flags.carry);
    endproperty
    a_xor_val: assert property (p_xor_val)
        else $error("xor with file result wrong");

    property p_rot_left;
        ex_go && instr[13:8] == 6'b00_1101 |=>
            flags.carry == $past(src[7]) &&
            res_r[0] == $past(flags.carry) && $stable(flags.zero);
    endproperty
    a_rot_left: assert property (p_rot_left)
        else $error("rotate left through carry wrong");

    property p_bit_clear;
        ex_go && instr[13:10] == 4'b0100 |=>
            file_wr.we && file_wr.data[$past(bsel)] == 1'b0 && $stable(flags);
    endproperty
    a_bit_clear: assert property (p_bit_clear)
        else $error("bit clear failed");

    property p_test_clear;
        ex_go && instr[13:10] == 4'b0110 && src[bsel] == 1'b0 |=>
            s_nop_cycle;
    endproperty
    a_test_clear: assert property (p_test_clear)
        else $error("test bit clear did not skip");

    property p_return_loading_literal;
        ex_go && instr[13:10] == 4'b1101 |=>
            pop && acc == $past(instr[7:0]) ##1 !pop;
    endproperty
    a_return_loading_literal: assert property (p_return_loading_literal)
        else $error("return with literal wrong");

    property p_sleep;
        ex_go && instr == {6'h00, MDEC_W_SLEEP} |=>
            sleep_req && !flags.powerdown_flag && flags.watchdog_expired_flag;
    endproperty
    a_sleep: assert property (p_sleep)
        else $error("standby entry wrong");

    property p_port_src;
        instr[6:0] == PORT_B_ADDR |-> src == pin_b_r;
    endproperty
    a_port_src: assert property (p_port_src)
        else $error("port source not pin levels");

    property p_presc;
        ex_go && instr[13:10] == 4'b0101 && instr[6:0] == TIMER_ADDR &&
            presc_assign_r |=> presc_clear;
    endproperty
    a_presc: assert property (p_presc)
        else $error("prescaler not cleared");

    property p_long;
        s_long_op |=> !ex_go ##1 state_r == MDEC_S_EXEC;
    endproperty
    a_long: assert property (p_long)
        else $error("second cycle not a no-op");

endmodule

// File: hw/mdec_pkg.sv
// Package of constants and carrier types for the instruction decoder.
package mdec_pkg;

    // Register port offsets.
    localparam logic [1:0] MDEC_OFS_CTRL = 2'h0;
    localparam logic [1:0] MDEC_OFS_ACC = 2'h1;
    localparam logic [1:0] MDEC_OFS_STAT = 2'h2;

    // Field positions inside the control and status registers.
    localparam int MDEC_CTRL_PRESC_BIT = 0;
    localparam int MDEC_STAT_C_BIT = 0;
    localparam int MDEC_STAT_HC_BIT = 1;
    localparam int MDEC_STAT_Z_BIT = 2;
    localparam int MDEC_STAT_WDX_BIT = 3;
    localparam int MDEC_STAT_PWD_BIT = 4;

    // Values after reset.
    localparam logic [7:0] MDEC_ACC_RST = 8'h00;
    localparam logic MDEC_PRESC_RST = 1'b1;
    localparam logic MDEC_WDX_RST = 1'b1;
    localparam logic MDEC_PWD_RST = 1'b1;

    // Fixed control words, low byte with the upper six bits clear, or 6'b00_0001 for MDEC_W_CLRACC.
    localparam logic [7:0] MDEC_W_RETURN = 8'h08;
    localparam logic [7:0] MDEC_W_INTRET = 8'h09;
    localparam logic [7:0] MDEC_W_SLEEP = 8'h63;
    localparam logic [7:0] MDEC_W_WDKICK = 8'h64;
    localparam logic [7:0] MDEC_W_CLRACC = 8'h03;

    // Cycles taken by an instruction whose second cycle is a no-op.
    localparam int MDEC_LONG_CYCLES = 2;

    typedef enum logic [0:0] {
        MDEC_S_EXEC = 1'b0,
        MDEC_S_NOP = 1'b1
    } mdec_state_t;

    typedef struct packed {
        logic we;
        logic [6:0] addr;
        logic [7:0] data;
    } mdec_fwr_t;

    typedef struct packed {
        logic powerdown_flag;
        logic watchdog_expired_flag;
        logic zero;
        logic half_carry_flag;
        logic carry;
    } mdec_flags_t;

    typedef struct packed {
        logic hc;
        logic c;
        logic [7:0] v;
    } mdec_sum_t;

endpackage

// File: test/mdec_file_model.sv
// Behavioural model of the data file registers beside the decoder.
`timescale 1ns/1ps
module mdec_file_model (
    // Clock.
    input wire logic clk,
    // Lookup address and write port.
    input wire logic [13:0] instr,
    input wire mdec_pkg::mdec_fwr_t file_wr,
    // Contents at the looked-up address.
    output logic [7:0] file_rdata
);
    import mdec_pkg::*;
    logic [7:0] mem [128];
    // The lookup is combinational so data stand in the cycle of the word.
    assign file_rdata = mem[instr[6:0]];
    always @(posedge clk) begin
        if (file_wr.we) begin
            mem[file_wr.addr] <= file_wr.data;
        end
    end
endmodule

// File: test/mdec_core_tb.sv
// Self-checking bench of the instruction decoder.
`timescale 1ns/1ps
module mdec_core_tb;
    import mdec_pkg::*;
    localparam logic [6:0] TMR = 7'h01;
    localparam logic [6:0] PA = 7'h05;
    localparam logic [6:0] PB = 7'h06;
    logic clk, rst_b, instr_valid, reg_wr, reg_rd, d, s;
    logic [13:0] instr, w;
    logic [7:0] file_rdata, pin_a, pin_b, reg_wdata, reg_rdata, acc;
    logic [7:0] f, r, t, k, v, ea, pe, pulses;
    logic [1:0] reg_addr;
    logic [6:0] a;
    logic [3:0] op;
    logic [4:0] ef;
    logic [10:0] jump_addr;
    logic [31:0] rnd;
    logic flush, jump, push, pop, gie_set, sleep_req, watchdog_clear;
    logic presc_clear;
    mdec_fwr_t file_wr;
    mdec_flags_t flags;
    int error_cnt, samples_checked, i;
    logic [3:0] ops [6] = '{4'h4, 4'h6, 4'h7, 4'h2, 4'hd, 4'hc};
    logic [13:0] cw [6] = '{14'h2000, 14'h2800, 14'h0008, 14'h0009,
        14'h0063, 14'h0064};
    logic [7:0] cp [6] = '{8'he0, 8'hc0, 8'h90, 8'h98, 8'h06, 8'h02};

    assign pulses = {flush, jump, push, pop, gie_set, sleep_req,
        watchdog_clear, presc_clear};

    mdec_core #(.TIMER_ADDR(TMR), .PORT_A_ADDR(PA), .PORT_B_ADDR(PB)) u_dut (
        .clk(clk), .rst_b(rst_b), .instr_valid(instr_valid), .instr(instr),
        .file_rdata(file_rdata), .pin_a(pin_a), .pin_b(pin_b),
        .file_wr(file_wr), .flush(flush), .jump(jump),
        .jump_addr(jump_addr), .push(push), .pop(pop), .gie_set(gie_set),
        .sleep_req(sleep_req), .watchdog_clear(watchdog_clear),
        .presc_clear(presc_clear), .flags(flags), .acc(acc),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata)
    );
    mdec_file_model u_file (
        .clk(clk), .instr(instr), .file_wr(file_wr), .file_rdata(file_rdata)
    );

    ////////////////////////////////////////////////////////////////////////
    function automatic logic [7:0] roll();
        rnd = {rnd[30:0], rnd[31] ^ rnd[21] ^ rnd[1] ^ rnd[0]};
        return rnd[7:0];
    endfunction

    task automatic chk(input string n, input logic [15:0] seen,
            input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", n, exp, seen);
        end
    endtask

    task automatic close_out();
        $display("checks %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic reg_write(input logic [1:0] ad, input logic [7:0] dt);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= ad;
        reg_wdata <= dt;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask

    task automatic reg_read(input logic [1:0] ad, output logic [7:0] dt);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= ad;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        dt = reg_rdata;
    endtask

    // With hold set, the word 14'h38ff stays valid in the cycle after the taking edge.
    task automatic exec(input logic [13:0] word, input logic hold);
        @(posedge clk);
        instr_valid <= 1'b1;
        instr <= word;
        @(posedge clk);
        instr_valid <= hold;
        instr <= 14'h38ff;
        #1;
    endtask

    task automatic drop();
        @(posedge clk);
        instr_valid <= 1'b0;
        #1;
        chk("discard we", file_wr.we, 1'b0);
        chk("discard acc", acc, ea);
    endtask

    // Model contents are set after the edge that lands a pending file write.
    task automatic put(input logic [6:0] ad, input logic [7:0] vl);
        @(posedge clk);
        #1;
        u_file.mem[ad] = vl;
    endtask

    task automatic alu(input logic [3:0] o, input logic [7:0] x);
        logic [8:0] sum;
        case (o)
            4'h4: r = ea | x;
            4'h6: r = ea ^ x;
            4'h7: begin
                sum = x + ea;
                r = sum[7:0];
                ef[0] = sum[8];
                ef[1] = ({1'b0, x[3:0]} + {1'b0, ea[3:0]}) > 5'd15;
            end
            4'h2: begin
                r = x - ea;
                ef[0] = x >= ea;
                ef[1] = x[3:0] >= ea[3:0];
            end
            4'hd: begin
                r = {x[6:0], ef[0]};
                ef[0] = x[7];
            end
            default: begin
                r = {ef[0], x[7:1]};
                ef[0] = x[0];
            end
        endcase
        if (o != 4'hd && o != 4'hc) begin
            ef[2] = (r == 8'h00);
        end
    endtask

    task automatic expect_out(input logic dd, input logic [6:0] ad,
            input logic [7:0] res, input logic [7:0] pz);
        chk("we", file_wr.we, dd);
        if (dd) begin
            chk("write", {file_wr.addr, file_wr.data}, {ad, res});
        end else begin
            ea = res;
        end
        chk("acc", acc, ea);
        chk("flags", flags, ef);
        chk("pulses", pulses, pz);
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    initial begin
        #2000000;
        error_cnt++;
        close_out();
    end

    initial begin
        rst_b = 1'b0;
        instr_valid = 1'b0;
        instr = 14'h0;
        pin_a = 8'h00;
        pin_b = 8'h00;
        reg_addr = 2'h0;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        error_cnt = 0;
        samples_checked = 0;
        rnd = 32'h7acc;
        ef = 5'b11000;
        ea = 8'h00;
        repeat (16) @(posedge clk);
        rst_b <= 1'b1;
        #1;
        chk("acc", acc, ea);
        chk("flags", flags, ef);
        reg_read(MDEC_OFS_CTRL, v);
        chk("ctrl", v, 8'h01);
        reg_read(MDEC_OFS_STAT, v);
        chk("stat", v, {3'h0, ef});
        reg_read(2'h3, v);
        chk("unmapped", v, 8'h00);
        $display("test reset done");
        for (i = 0; i < 36; i++) begin
            op = ops[i % 6];
            f = roll();
            t = roll();
            a = (t[1:0] == 2'h0) ? TMR : (t[1:0] == 2'h1) ? PA :
                (t[1:0] == 2'h2) ? 7'h20 : PB;
            d = t[2] | (a == PA) | (a == PB);
            pin_a <= f;
            pin_b <= f;
            put(a, (a == PA || a == PB) ? ~f : f);
            reg_write(MDEC_OFS_CTRL, {7'h0, t[3]});
            reg_write(MDEC_OFS_ACC, t ^ f);
            ea = t ^ f;
            alu(op, f);
            pe = {7'h0, d && a == TMR && t[3]};
            w = {2'b00, op, d, a};
            exec(w, 1'b0);
            expect_out(d, a, r, pe);
        end
        $display("test byte ops done");
        for (i = 0; i < 4; i++) begin
            f = (i == 0) ? 8'h01 : (i == 2) ? 8'hff : roll() | 8'h10;
            r = (i < 2) ? f - 8'h01 : f + 8'h01;
            s = (r == 8'h00);
            put(7'h20, f);
            exec({2'b00, (i < 2) ? 4'hb : 4'hf, 8'ha0}, s);
            expect_out(1'b1, 7'h20, r, {s, 7'h0});
            if (s) begin
                drop();
            end
        end
        for (i = 0; i < 8; i++) begin
            f = roll();
            put(7'h20, f);
            exec({4'b0100, i[2:0], 7'h20}, 1'b0);
            expect_out(1'b1, 7'h20, f & ~(8'h01 << i), 8'h00);
            put(7'h20, f);
            s = ~f[i];
            exec({4'b0110, i[2:0], 7'h20}, s);
            chk("pulses", pulses, {s, 7'h0});
            if (s) begin
                drop();
            end
            s = f[i];
            exec({4'b0111, i[2:0], 7'h20}, s);
            chk("pulses", pulses, {s, 7'h0});
            chk("flags", flags, ef);
            if (s) begin
                drop();
            end
        end
        $display("test skips done");
        for (i = 0; i < 4; i++) begin
            k = roll();
            t = roll();
            alu(4'h4, k);
            exec({6'b111000, k}, 1'b0);
            expect_out(1'b0, 7'h0, r, 8'h00);
            alu(4'h2, k);
            exec({5'b11110, t[0], k}, 1'b0);
            expect_out(1'b0, 7'h0, r, 8'h00);
            exec({4'b1101, t[2:1], k}, 1'b0);
            expect_out(1'b0, 7'h0, k, 8'h90);
        end
        $display("test literals done");
        for (i = 0; i < 6; i++) begin
            k = roll();
            t = roll();
            w = cw[i] | ((i < 2) ? {3'h0, t[2:0], k} : 14'h0);
            ef[4:3] = (i == 4) ? 2'b01 : (i == 5) ? 2'b11 : ef[4:3];
            exec(w, 1'b0);
            chk("pulses", pulses, cp[i]);
            chk("flags", flags, ef);
            if (i < 2) begin
                chk("jump_addr", jump_addr, {t[2:0], k});
            end
        end
        reg_read(MDEC_OFS_STAT, v);
        chk("stat", v, {3'h0, ef});
        $display("test control done");
        close_out();
    end
endmodule
